// File: hw/tlih_handler.sv
// two-level interrupt handler with ahb-lite register slave
//
// Our own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Functional notes
// - hardware event sets source pending flag
// - flag sets even when source disabled
// - enabled pending forces call after instruction
// - routine ends with return; core resumes
// - disabled source raises no request
// - per-source enable in basic/extended register
// - global gate bit 7 masks everything
// - gated requests stay pending until reopened
// - some flags cleared by hardware on vector
// - still-pending flag re-requests after return
// - fifteen sources, own vector and order
// - software set behaves like hardware event
// - per-source priority bit, low or high
// - high preempts low, high never preempted
// - priorities reset to low
// - higher level first, then fixed order
// - requests sampled every clock cycle
// - minimum response five clock cycles
// - equal-or-higher routine blocks new request
module tlih_handler (
	input  wire logic                 core_clk,
	input  wire logic                 reset,
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic      [31:0]          hrdata,
	output logic                      hreadyout,
	output logic                      hresp,
	input  wire logic [14:0]          src_event,
	input  wire logic                 insn_boundary,
	input  wire logic                 call_ack,
	input  wire logic                 return_from_interrupt_done,
	output tlih_pkg::tlih_req_t       call_req,
	output logic      [14:0]          pending_flags,
	output logic      [1:0]           level_active
);
	logic [7:0]                basic_enable_register;
	logic [7:0]                extended_enable_register;
	logic [7:0]                basic_priority_register;
	logic [7:0]                extended_priority_register;
	logic [14:0]               pend_reg;
	logic [14:0]               autoclr_reg;
	logic [1:0]                active_reg;
	logic                      hold_reg;
	logic [2:0]                cnt_reg;
	tlih_pkg::tlih_state_t     state_reg;
	tlih_pkg::tlih_req_t       req_reg;
	logic                      wr_pend_reg;
	logic [7:0]                wr_addr_reg;
	logic [14:0]               en_vec;
	logic [14:0]               pr_vec;
	logic [14:0]               live;
	logic                      global_irq_gate;
	logic                      ap_valid;
	tlih_pkg::tlih_req_t       pick;
	logic                      sw_set_wr;
	logic                      sw_clr_wr;
	logic [14:0]               hw_clr;
	logic                      vec_fire;

	// lowest index wins among the given mask
	function automatic logic [4:0] first_set(input logic [14:0] m);
		first_set = 5'h1f;
		for (int i = tlih_pkg::NUM_SRC - 1; i >= 0; i--) begin
			if (m[i]) begin
				first_set = 5'(i);
			end
		end
	endfunction

	function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] r);
		reg_hit = (a == r);
	endfunction

	// ---- bus slave: zero wait states
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign ap_valid  = hsel && htrans[1] && hready;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end else begin
			wr_pend_reg <= ap_valid && hwrite;
			wr_addr_reg <= {haddr[7:2], 2'b00};
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			hrdata <= 32'h0000_0000;
		end else if (ap_valid && !hwrite) begin
			case ({haddr[7:2], 2'b00})
				tlih_pkg::ADDR_BASIC_EN: hrdata <= {24'h000000, basic_enable_register};
				tlih_pkg::ADDR_EXT_EN:   hrdata <= {24'h000000, extended_enable_register};
				tlih_pkg::ADDR_BASIC_PR: hrdata <= {24'h000000, basic_priority_register};
				tlih_pkg::ADDR_EXT_PR:   hrdata <= {24'h000000, extended_priority_register};
				tlih_pkg::ADDR_PENDING:  hrdata <= {17'h00000, pend_reg};
				tlih_pkg::ADDR_STATUS:   hrdata <= {22'h000000, hold_reg, active_reg,
					state_reg, 3'h0};
				tlih_pkg::ADDR_AUTOCLR:  hrdata <= {17'h00000, autoclr_reg};
				default:                 hrdata <= 32'h0000_0000;
			endcase
		end
	end

	assign sw_set_wr = wr_pend_reg && reg_hit(wr_addr_reg, tlih_pkg::ADDR_PENDING);
	assign sw_clr_wr = wr_pend_reg && reg_hit(wr_addr_reg, tlih_pkg::ADDR_CLEAR);

	// enable and priority registers, priorities reset low
	always_ff @(posedge core_clk) begin
		if (reset) begin
			basic_enable_register      <= tlih_pkg::EN_RESET;
			extended_enable_register   <= tlih_pkg::EN_RESET;
			basic_priority_register    <= tlih_pkg::PR_RESET;
			extended_priority_register <= tlih_pkg::PR_RESET;
			autoclr_reg                <= tlih_pkg::AUTOCLR_RESET;
		end else if (wr_pend_reg) begin
			if (reg_hit(wr_addr_reg, tlih_pkg::ADDR_BASIC_EN)) begin
				basic_enable_register <= hwdata[7:0];
			end
			if (reg_hit(wr_addr_reg, tlih_pkg::ADDR_EXT_EN)) begin
				extended_enable_register <= hwdata[7:0];
			end
			if (reg_hit(wr_addr_reg, tlih_pkg::ADDR_BASIC_PR)) begin
				basic_priority_register <= {1'b0, hwdata[6:0]};
			end
			if (reg_hit(wr_addr_reg, tlih_pkg::ADDR_EXT_PR)) begin
				extended_priority_register <= hwdata[7:0];
			end
			if (reg_hit(wr_addr_reg, tlih_pkg::ADDR_AUTOCLR)) begin
				autoclr_reg <= hwdata[14:0];
			end
		end
	end

	// global gate is bit 7 of the basic enable
	assign global_irq_gate = basic_enable_register[tlih_pkg::GATE_BIT];
	assign en_vec = {extended_enable_register, basic_enable_register[6:0]};
	assign pr_vec = {extended_priority_register, basic_priority_register[6:0]};

	// hardware clear of auto-clear flags on vector
	always_comb begin
		hw_clr = 15'h0000;
		if (vec_fire) begin
			hw_clr[req_reg.index] = autoclr_reg[req_reg.index];
		end
	end

	// flags set regardless of enables; set wins over clear
	generate
		for (genvar g = 0; g < tlih_pkg::NUM_SRC; g++) begin : g_pend
			always_ff @(posedge core_clk) begin
				if (reset) begin
					pend_reg[g] <= 1'b0;
				end else if (src_event[g] || (sw_set_wr && hwdata[g])) begin
					pend_reg[g] <= 1'b1;
				end else if (hw_clr[g] || (sw_clr_wr && hwdata[g])) begin
					pend_reg[g] <= 1'b0;
				end
			end
		end
	endgenerate
	assign pending_flags = pend_reg;

	// only enabled flags under an open gate are live
	assign live = global_irq_gate ? (pend_reg & en_vec) : 15'h0000;

	always_comb begin
		logic [14:0] hi;
		logic [4:0]  idx;
		hi   = live & pr_vec;
		pick = '0;
		idx  = 5'h1f;
		if (|hi && !active_reg[1]) begin
			idx       = first_set(hi);
			pick.high = 1'b1;
		end else if (|live && active_reg == 2'b00) begin
			idx = first_set(live);
		end
		if (idx != 5'h1f) begin
			pick.valid  = 1'b1;
			pick.index  = idx[3:0];
			pick.vector = tlih_pkg::VEC_BASE + (16'(idx) << tlih_pkg::VEC_SHIFT);
		end
	end

	// detect, wait for boundary, four cycle call
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_reg <= tlih_pkg::TLIH_IDLE;
			req_reg   <= '0;
			cnt_reg   <= 3'h0;
		end else begin
			case (state_reg)
				tlih_pkg::TLIH_IDLE: begin
					if (pick.valid && !hold_reg) begin
						state_reg <= tlih_pkg::TLIH_WAIT;
					end
				end
				tlih_pkg::TLIH_WAIT: begin
					if (!pick.valid) begin
						state_reg <= tlih_pkg::TLIH_IDLE;
					end else if (insn_boundary) begin
						req_reg   <= pick;
						// capture edge is the first of the call cycles
						cnt_reg   <= 3'(tlih_pkg::CALL_CYCLES - 2);
						state_reg <= tlih_pkg::TLIH_CALL;
					end
				end
				tlih_pkg::TLIH_CALL: begin
					if (cnt_reg == 3'h0) begin
						state_reg <= tlih_pkg::TLIH_HOLD;
					end else begin
						cnt_reg <= cnt_reg - 3'h1;
					end
				end
				tlih_pkg::TLIH_HOLD: begin
					if (call_ack) begin
						req_reg.valid <= 1'b0;
						state_reg     <= tlih_pkg::TLIH_IDLE;
					end
				end
				default: state_reg <= tlih_pkg::TLIH_IDLE;
			endcase
		end
	end

	assign vec_fire = (state_reg == tlih_pkg::TLIH_HOLD) && call_ack;
	assign call_req = (state_reg == tlih_pkg::TLIH_HOLD) ? req_reg : '0;

	// level bookkeeping; return releases the most recent
	always_ff @(posedge core_clk) begin
		if (reset) begin
			active_reg <= 2'b00;
		end else if (vec_fire) begin
			active_reg[req_reg.high] <= 1'b1;
		end else if (return_from_interrupt_done) begin
			if (active_reg[1]) begin
				active_reg[1] <= 1'b0;
			end else begin
				active_reg[0] <= 1'b0;
			end
		end
	end
	assign level_active = active_reg;

	// one instruction must run after a return
	always_ff @(posedge core_clk) begin
		if (reset) begin
			hold_reg <= 1'b0;
		end else if (return_from_interrupt_done) begin
			hold_reg <= 1'b1;
		end else if (insn_boundary) begin
			hold_reg <= 1'b0;
		end
	end

	// no call request while gate shut at detection
	gated_quiet_a: assert property (@(posedge core_clk) disable iff (reset)
		(state_reg == tlih_pkg::TLIH_IDLE && !global_irq_gate) |=>
		state_reg != tlih_pkg::TLIH_WAIT)
		else $error("request raised while gate closed");

	// call issued four cycles after capture
	sequence s_capture;
		state_reg == tlih_pkg::TLIH_WAIT && pick.valid && insn_boundary;
	endsequence
	call_timing_a: assert property (@(posedge core_clk) disable iff (reset)
		s_capture |-> ##4 (call_req.valid && state_reg == tlih_pkg::TLIH_HOLD))
		else $error("call timing wrong");

	pend_set_a: assert property (@(posedge core_clk) disable iff (reset)
		src_event[0] |=> pend_reg[0])
		else $error("event did not set flag");

	sw_set_a: assert property (@(posedge core_clk) disable iff (reset)
		(sw_set_wr && hwdata[3]) |=> pend_reg[3])
		else $error("software set ignored");

	hi_noempt_a: assert property (@(posedge core_clk) disable iff (reset)
		active_reg[1] |-> !pick.valid)
		else $error("high routine preempted");

	vec_map_a: assert property (@(posedge core_clk) disable iff (reset)
		pick.valid |-> pick.vector == tlih_pkg::VEC_BASE + (16'(pick.index) << 3))
		else $error("vector mismatch");

	prio_first_a: assert property (@(posedge core_clk) disable iff (reset)
		(pick.valid && |(live & pr_vec) && !active_reg[1]) |-> pick.high)
		else $error("low picked over high");

	level_mark_a: assert property (@(posedge core_clk) disable iff (reset)
		vec_fire |=> active_reg[$past(req_reg.high)])
		else $error("level not marked");

	auto_clr_a: assert property (@(posedge core_clk) disable iff (reset)
		(vec_fire && autoclr_reg[req_reg.index] && !src_event[req_reg.index]
		&& !sw_set_wr) |=> !pend_reg[$past(req_reg.index)])
		else $error("auto clear missed");

	return_from_interrupt_hold_a: assert property (@(posedge core_clk) disable iff (reset)
		return_from_interrupt_done |=> hold_reg)
		else $error("return not followed by one instruction");

	// low request waits while any level active
	low_wait_a: assert property (@(posedge core_clk) disable iff (reset)
		(pick.valid && !pick.high) |-> (active_reg == 2'b00))
		else $error("low request while routine active");

	call_hold_a: assert property (@(posedge core_clk) disable iff (reset)
		(call_req.valid && !call_ack) |=> (call_req.valid && $stable(call_req)))
		else $error("call request dropped before acknowledge");

	// priorities come out of reset low
	prio_low_a: assert property (@(posedge core_clk)
		reset |=> (pr_vec == 15'h0000))
		else $error("priority not low after reset");

	// return releases the high level first
	level_free_a: assert property (@(posedge core_clk) disable iff (reset)
		(return_from_interrupt_done && !vec_fire && active_reg[1]) |=> !active_reg[1])
		else $error("return did not release high level");

	// no new request until an instruction ends
	hold_block_a: assert property (@(posedge core_clk) disable iff (reset)
		(hold_reg && state_reg == tlih_pkg::TLIH_IDLE) |=>
		(state_reg == tlih_pkg::TLIH_IDLE))
		else $error("request raised before instruction after return");

	keep_flag_a: assert property (@(posedge core_clk) disable iff (reset)
		(vec_fire && pend_reg[req_reg.index] && !autoclr_reg[req_reg.index]
		&& !sw_clr_wr) |=> pend_reg[$past(req_reg.index)])
		else $error("flag cleared without auto clear");
endmodule

// File: hw/tlih_pkg.sv
// shared constants and types for the two-level interrupt handler
package tlih_pkg;
	localparam int          NUM_SRC       = 15;
	localparam int          GATE_BIT      = 7;
	// register byte addresses on the bus
	localparam logic [7:0]  ADDR_BASIC_EN = 8'h00;
	localparam logic [7:0]  ADDR_EXT_EN   = 8'h04;
	localparam logic [7:0]  ADDR_BASIC_PR = 8'h08;
	localparam logic [7:0]  ADDR_EXT_PR   = 8'h0c;
	localparam logic [7:0]  ADDR_PENDING  = 8'h10;
	localparam logic [7:0]  ADDR_CLEAR    = 8'h14;
	localparam logic [7:0]  ADDR_STATUS   = 8'h18;
	localparam logic [7:0]  ADDR_AUTOCLR  = 8'h1c;
	// reset values
	localparam logic [7:0]  EN_RESET      = 8'h00;
	localparam logic [7:0]  PR_RESET      = 8'h00;
	localparam logic [14:0] AUTOCLR_RESET = 15'h000f;
	// vector layout: base + 8 * index
	localparam logic [15:0] VEC_BASE      = 16'h0003;
	localparam int          VEC_SHIFT     = 3;
	// call cycles from capture to call issue, capture included (detect adds 1 more)
	localparam int          CALL_CYCLES   = 4;

	typedef enum logic [3:0] {
		TLIH_IDLE = 4'b0001,
		TLIH_WAIT = 4'b0010,
		TLIH_CALL = 4'b0100,
		TLIH_HOLD = 4'b1000
	} tlih_state_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] vector;
		logic [3:0]  index;
		logic        high;
	} tlih_req_t;
endpackage

// File: verification/tlih_core_model.sv
// core sequencer model on the far side of the handler
`timescale 1ns/1ps
module tlih_core_model (
	input  wire logic                core_clk,
	input  wire logic                reset,
	input  wire tlih_pkg::tlih_req_t call_req,
	input  wire logic                slow,
	input  wire logic                ret_req,
	output logic                     insn_boundary,
	output logic                     call_ack,
	output logic                     return_from_interrupt_done
);
	logic [1:0] cnt_reg;
	always_ff @(posedge core_clk) begin
		if (reset) begin
			cnt_reg <= 2'h0;
			call_ack <= 1'b0;
		end else begin
			cnt_reg <= cnt_reg + 2'h1;
			call_ack <= call_req.valid && !call_ack && (!slow || cnt_reg == 2'h3);
		end
	end
	// instruction ends every other cycle
	assign insn_boundary = cnt_reg[0];
	always_ff @(posedge core_clk) begin
		return_from_interrupt_done <= ret_req && !reset;
	end
endmodule

// File: verification/testbench.sv
// self-checking bench for the two-level interrupt handler
`timescale 1ns/1ps
module testbench;
	logic                core_clk = 1'b0;
	logic                reset = 1'b1;
	logic                hsel = 1'b0;
	logic [31:0]         haddr = 32'h0;
	logic [1:0]          htrans = 2'h0;
	logic                hwrite = 1'b0;
	logic [2:0]          hsize = 3'h2;
	logic [31:0]         hwdata = 32'h0;
	logic [14:0]         src_event = 15'h0;
	logic                slow = 1'b0;
	logic                ret_req = 1'b0;
	logic [31:0]         hrdata, rd;
	logic                hreadyout, hresp, insn_boundary, call_ack, return_from_interrupt_done;
	logic [14:0]         pending_flags;
	logic [1:0]          level_active;
	tlih_pkg::tlih_req_t call_req;
	int                  bad_count = 0;
	int                  cmp_count = 0;
	int                  a, b, w, pr, lat;
	always #2.5 core_clk = ~core_clk;
	tlih_handler u_dut (.core_clk(core_clk), .reset(reset), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .src_event(src_event),
		.insn_boundary(insn_boundary), .call_ack(call_ack),
		.return_from_interrupt_done(return_from_interrupt_done), .call_req(call_req),
		.pending_flags(pending_flags), .level_active(level_active));
	tlih_core_model u_core (.core_clk(core_clk), .reset(reset),
		.call_req(call_req), .slow(slow), .ret_req(ret_req),
		.insn_boundary(insn_boundary), .call_ack(call_ack),
		.return_from_interrupt_done(return_from_interrupt_done));
	task automatic complete_run();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, ad};
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	// waits for the call, checks it, then waits for the acknowledge
	task automatic take(input int i, input logic h);
		lat = 0;
		while (call_req.valid !== 1'b1 && lat < 80) begin
			@(posedge core_clk);
			lat++;
		end
		chk(32'({call_req.index, call_req.vector}), 32'({i[3:0], 16'(3 + 8 * i)}), "vector");
		chk(32'(call_req.high), 32'(h), "level");
		repeat (12) if (call_req.valid === 1'b1) @(posedge core_clk);
	endtask
	task automatic ret();
		ret_req <= 1'b1;
		@(posedge core_clk);
		ret_req <= 1'b0;
		repeat (2) @(posedge core_clk);
	endtask
	task automatic serve(input int i, input logic h);
		take(i, h);
		if (i > 3)
			bus(1'b1, tlih_pkg::ADDR_CLEAR, 32'(1 << i));
		ret();
	endtask
	// reference arbiter: high level first, then lowest index
	function automatic int win(input int pm, input int prm);
		for (int k = 0; k < 15; k++)
			if (pm[k] && prm[k])
				return k;
		for (int k = 0; k < 15; k++)
			if (pm[k])
				return k;
		return 0;
	endfunction
	initial begin
		#200000;
		bad_count++;
		complete_run();
	end
	initial begin
		void'($urandom(32'h7f89f001));
		repeat (6) @(posedge core_clk);
		reset <= 1'b0;
		bus(1'b0, tlih_pkg::ADDR_BASIC_PR, 32'h0);
		chk(rd, 32'h0, "basic priority reset");
		bus(1'b0, tlih_pkg::ADDR_EXT_PR, 32'h0);
		chk(rd, 32'h0, "ext priority reset");
		bus(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h0, "unmapped read");
		$display("test reset done");
		bus(1'b1, tlih_pkg::ADDR_EXT_EN, 32'hff);
		bus(1'b1, tlih_pkg::ADDR_BASIC_EN, 32'h7f);
		src_event <= 15'h0041;
		@(posedge core_clk);
		src_event <= 15'h0;
		repeat (20) @(posedge core_clk);
		chk(32'(pending_flags), 32'h41, "flag while gated");
		chk(32'(call_req.valid), 32'h0, "gated request");
		bus(1'b1, tlih_pkg::ADDR_BASIC_EN, 32'hff);
		serve(0, 1'b0);
		serve(6, 1'b0);
		chk(32'(level_active), 32'h0, "level released");
		$display("test gate done");
		for (int i = 0; i < 15; i++) begin
			slow <= i[0];
			bus(1'b1, tlih_pkg::ADDR_PENDING, 32'(1 << i));
			take(i, 1'b0);
			chk(32'(lat >= 5), 32'h1, "latency");
			chk(32'(pending_flags[i]), 32'(i > 3), "auto clear");
			if (i > 3 && i != 8)
				bus(1'b1, tlih_pkg::ADDR_CLEAR, 32'(1 << i));
			ret();
			if (i == 8) begin
				take(8, 1'b0);
				bus(1'b1, tlih_pkg::ADDR_CLEAR, 32'(1 << i));
				ret();
			end
		end
		$display("test sources done");
		bus(1'b1, tlih_pkg::ADDR_BASIC_PR, 32'h02);
		bus(1'b1, tlih_pkg::ADDR_EXT_PR, 32'h08);
		bus(1'b1, tlih_pkg::ADDR_PENDING, 32'h200);
		take(9, 1'b0);
		bus(1'b1, tlih_pkg::ADDR_PENDING, 32'h2);
		take(1, 1'b1);
		chk(32'(level_active), 32'h3, "nested levels");
		bus(1'b1, tlih_pkg::ADDR_PENDING, 32'h400);
		repeat (30) @(posedge core_clk);
		chk(32'(call_req.valid), 32'h0, "high not preempted");
		ret();
		take(10, 1'b1);
		bus(1'b1, tlih_pkg::ADDR_CLEAR, 32'h600);
		ret();
		ret();
		chk(32'(level_active), 32'h0, "all released");
		$display("test preempt done");
		for (int r = 0; r < 4; r++) begin
			a = $urandom % 15;
			b = (a + 1 + $urandom % 14) % 15;
			pr = $urandom % 32768;
			bus(1'b1, tlih_pkg::ADDR_BASIC_EN, 32'h7f);
			bus(1'b1, tlih_pkg::ADDR_BASIC_PR, 32'(pr[6:0]));
			bus(1'b1, tlih_pkg::ADDR_EXT_PR, 32'(pr[14:7]));
			bus(1'b1, tlih_pkg::ADDR_PENDING, 32'((1 << a) | (1 << b)));
			bus(1'b1, tlih_pkg::ADDR_BASIC_EN, 32'hff);
			w = win((1 << a) | (1 << b), pr);
			serve(w, pr[w]);
			w = a + b - w;
			serve(w, pr[w]);
		end
		$display("test arbitration done");
		complete_run();
	end
endmodule
